// ==== verilog/srla_map.svh ====
`ifndef SRLA_MAP_SVH
`define SRLA_MAP_SVH
`define SRLA_ADDR_LINK_CTRL 12'h300
`define SRLA_ADDR_SUBCLASS 12'h301
`define SRLA_ADDR_LAT0 12'h302
`define SRLA_ADDR_LAT1 12'h303
`define SRLA_ADDR_MFOFS0 12'h304
`define SRLA_ADDR_MFOFS1 12'h305
`define SRLA_ADDR_RBD0 12'h306
`define SRLA_ADDR_RBD1 12'h307
`define SRLA_RST_LINK_EN 2'h0
`define SRLA_RST_SUBCLASS 3'h1
`define SRLA_RST_MFOFS 5'h00
`define SRLA_RST_RBD 5'h06
`define SRLA_RBD_MAX 5'h0a
`define SRLA_SUBCLASS0 3'h0
`define SRLA_SUBCLASS1 3'h1
`endif

// ==== verilog/srla_pkg.sv ====
package srla_pkg;
	typedef enum logic [1:0] {
		SRLA_IDLE = 2'b00,
		SRLA_WAIT_MF = 2'b01,
		SRLA_COUNT = 2'b10,
		SRLA_DONE = 2'b11
	} srla_meas_t;
endpackage : srla_pkg

// ==== verilog/srla_core.sv ====
// What this block does
// - Enable code 0b10 link1 only, 0b11 both
// - Enable code 0b00 none, 0b01 link0 only
// - Subclass code 000/001, reset subclass 1
// - Measure rx multiframe clock to next boundary
// - Delay internal multiframe clock per link
// - Read-buffer delay per link, reset six
`timescale 1ns/10ps
`include "srla_map.svh"
module srla_core #(
	parameter int DW = 5
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic frame_tick_in,
	input wire logic multiframe_clock_in,
	input wire logic [1:0] sync_done_in,
	input wire logic [1:0] boundary_in,
	input wire logic [1:0] rx_data_valid_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [11:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	output logic [1:0] link_enable_out,
	output logic rx_multiframe_clock0_out,
	output logic rx_multiframe_clock1_out,
	output logic [1:0] buffer_read_out
);
	logic [1:0] link_en_q;
	logic [2:0] subclass_select_q;
	logic [DW-1:0] mf_ofs_q [2];
	logic [DW-1:0] rbd_q [2];
	logic [DW-1:0] lat_q [2];
	logic [7:0] rdata_q;
	logic [1:0] rx_mfc;
	logic [1:0] rd_pulse_q;

	// Zero-extends a field to the byte the bus returns
	function automatic logic [7:0] pad5(input logic [DW-1:0] v);
		pad5 = {{(8-DW){1'b0}}, v};
	endfunction : pad5

	// Shared by the offset and read-delay down counters
	function automatic logic [DW-1:0] dec1(input logic [DW-1:0] v);
		dec1 = v - DW'(1);
	endfunction : dec1

	function automatic logic is_last(input logic [DW-1:0] v);
		is_last = (v == DW'(1));
	endfunction : is_last

	// Bit n of the enable field drives link n, giving all four codes
	assign link_enable_out = link_en_q;

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			link_en_q <= `SRLA_RST_LINK_EN;
			subclass_select_q <= `SRLA_RST_SUBCLASS;
			mf_ofs_q[0] <= `SRLA_RST_MFOFS;
			mf_ofs_q[1] <= `SRLA_RST_MFOFS;
			rbd_q[0] <= `SRLA_RST_RBD;
			rbd_q[1] <= `SRLA_RST_RBD;
		end else if (reg_wr_in) begin
			case (reg_addr_in)
				`SRLA_ADDR_LINK_CTRL: link_en_q <= reg_wdata_in[1:0];
				`SRLA_ADDR_SUBCLASS: subclass_select_q <= reg_wdata_in[2:0];
				`SRLA_ADDR_MFOFS0: mf_ofs_q[0] <= reg_wdata_in[DW-1:0];
				`SRLA_ADDR_MFOFS1: mf_ofs_q[1] <= reg_wdata_in[DW-1:0];
				// Values above ten are stored as written; software keeps them legal
				`SRLA_ADDR_RBD0: rbd_q[0] <= reg_wdata_in[DW-1:0];
				`SRLA_ADDR_RBD1: rbd_q[1] <= reg_wdata_in[DW-1:0];
				// Latency and unmapped writes land here and are dropped
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_q <= 8'h00;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				// Reserved bits read as zero
				`SRLA_ADDR_LINK_CTRL: rdata_q <= {6'h00, link_en_q};
				`SRLA_ADDR_SUBCLASS: rdata_q <= {5'h00, subclass_select_q};
				`SRLA_ADDR_LAT0: rdata_q <= pad5(lat_q[0]);
				`SRLA_ADDR_LAT1: rdata_q <= pad5(lat_q[1]);
				`SRLA_ADDR_MFOFS0: rdata_q <= pad5(mf_ofs_q[0]);
				`SRLA_ADDR_MFOFS1: rdata_q <= pad5(mf_ofs_q[1]);
				`SRLA_ADDR_RBD0: rdata_q <= pad5(rbd_q[0]);
				`SRLA_ADDR_RBD1: rdata_q <= pad5(rbd_q[1]);
				default: rdata_q <= 8'h00;
			endcase
		end
	end
	assign reg_rdata_out = rdata_q;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_link
			// Each link keeps its own offset, delay and latency path
			logic [DW-1:0] dly_cnt_q;
			logic dly_busy_q;
			logic mfc_q;
			logic mf_prev_q;
			logic mf_edge;
			logic step;
			srla_pkg::srla_meas_t st_q;
			logic [DW-1:0] meas_q;
			logic [DW-1:0] rd_cnt_q;
			logic rd_busy_q;
			logic sync_prev_q;

			assign mf_edge = multiframe_clock_in & ~mf_prev_q;
			// Subclass 1 counts frame clocks, subclass 0 counts core clocks
			assign step = (subclass_select_q == `SRLA_SUBCLASS1) ? frame_tick_in : 1'b1;

			always_ff @(posedge core_clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					// Starts low: a clock already high at release counts as one edge
					mf_prev_q <= 1'b0;
					dly_cnt_q <= '0;
					dly_busy_q <= 1'b0;
					mfc_q <= 1'b0;
				end else begin
					mf_prev_q <= multiframe_clock_in;
					mfc_q <= 1'b0;
					if (mf_edge && mf_ofs_q[g] == '0) begin
						mfc_q <= 1'b1;
					end else if (mf_edge) begin
						dly_busy_q <= 1'b1;
						dly_cnt_q <= mf_ofs_q[g];
					end else if (dly_busy_q && step) begin
						if (is_last(dly_cnt_q)) begin
							dly_busy_q <= 1'b0;
							mfc_q <= 1'b1;
						end
						dly_cnt_q <= dec1(dly_cnt_q);
					end
				end
			end
			assign rx_mfc[g] = mfc_q;

			// Measurement restarts on each rising sync_done while the link is enabled
			always_ff @(posedge core_clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					st_q <= srla_pkg::SRLA_IDLE;
					meas_q <= '0;
					lat_q[g] <= '0;
					sync_prev_q <= 1'b0;
				end else begin
					sync_prev_q <= sync_done_in[g];
					case (st_q)
						srla_pkg::SRLA_IDLE: begin
							if (link_en_q[g] && sync_done_in[g] && !sync_prev_q) begin
								st_q <= srla_pkg::SRLA_WAIT_MF;
							end
						end
						srla_pkg::SRLA_WAIT_MF: begin
							if (!link_en_q[g] || !sync_done_in[g]) begin
								st_q <= srla_pkg::SRLA_IDLE;
							end else if (rx_mfc[g]) begin
								meas_q <= '0;
								st_q <= srla_pkg::SRLA_COUNT;
							end
						end
						srla_pkg::SRLA_COUNT: begin
							// Saturate rather than wrap so an oversized gap reads as max
							// Leaving on a dropped link keeps the next bring-up from stalling
							if (!link_en_q[g] || !sync_done_in[g]) begin
								st_q <= srla_pkg::SRLA_IDLE;
							end else if (boundary_in[g]) begin
								lat_q[g] <= meas_q;
								st_q <= srla_pkg::SRLA_DONE;
							end else if (meas_q != '1) begin
								meas_q <= meas_q + DW'(1);
							end
						end
						srla_pkg::SRLA_DONE: begin
							if (!sync_done_in[g] || !link_en_q[g]) begin
								st_q <= srla_pkg::SRLA_IDLE;
							end
						end
						default: st_q <= srla_pkg::SRLA_IDLE;
					endcase
				end
			end

			// Buffer read strobe fires a fixed number of core clocks after rx mf clock
			// A new rx pulse while counting restarts the delay
			always_ff @(posedge core_clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					rd_cnt_q <= '0;
					rd_busy_q <= 1'b0;
					rd_pulse_q[g] <= 1'b0;
				end else begin
					rd_pulse_q[g] <= 1'b0;
					if (rx_mfc[g] && link_en_q[g] && rx_data_valid_in[g]) begin
						if (rbd_q[g] == '0) begin
							rd_pulse_q[g] <= 1'b1;
						end else begin
							rd_busy_q <= 1'b1;
							rd_cnt_q <= rbd_q[g];
						end
					end else if (rd_busy_q) begin
						if (is_last(rd_cnt_q)) begin
							rd_busy_q <= 1'b0;
							rd_pulse_q[g] <= 1'b1;
						end
						rd_cnt_q <= dec1(rd_cnt_q);
					end
				end
			end
		end
	endgenerate

	assign rx_multiframe_clock0_out = rx_mfc[0];
	assign rx_multiframe_clock1_out = rx_mfc[1];
	assign buffer_read_out = rd_pulse_q;
endmodule : srla_core

// ==== bench/srla_sva.sv ====
`timescale 1ns/10ps
module srla_sva (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic multiframe_clock_in,
	input wire logic [1:0] rx_data_valid_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [11:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic [1:0] link_enable_out,
	input wire logic rx_multiframe_clock0_out,
	input wire logic [1:0] buffer_read_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	wire logic en_wr = reg_wr_in && reg_addr_in == 12'h300;
	wire logic rx0 = rx_multiframe_clock0_out;
	a_en_set: assert property (en_wr |=> link_enable_out == $past(reg_wdata_in[1:0]))
		else $error("en set");
	a_en_hold: assert property (!en_wr |=> $stable(link_enable_out))
		else $error("en hold");
	a_lat_high: assert property (reg_rd_in && reg_addr_in[11:1] == 11'h181
		|=> reg_rdata_out[7:5] == 3'h0) else $error("lat high");
	// Offset 0 for link0 is never rewritten, so an edge must show next cycle
	a_rx_fast: assert property ($rose(multiframe_clock_in) |=> rx0)
		else $error("rx late");
	a_rx_once: assert property (rx0 |=> !rx0) else $error("rx long");
	a_rx_cause: assert property (rx0 |-> $past(multiframe_clock_in)
		&& !$past(multiframe_clock_in, 2)) else $error("rx cause");
	a_buf_time: assert property (rx0 && link_enable_out[0] && rx_data_valid_in[0]
		|-> ##7 buffer_read_out[0]) else $error("buf time");
	a_buf_once: assert property (buffer_read_out[0] |=> !buffer_read_out[0])
		else $error("buf long");
endmodule : srla_sva
bind srla_core srla_sva u_sva (.core_clk_in, .rst_n_in, .multiframe_clock_in, .rx_data_valid_in,
	.reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .link_enable_out,
	.rx_multiframe_clock0_out, .buffer_read_out);

// ==== bench/srla_far.sv ====
`timescale 1ns/10ps
module srla_far (
	input wire logic clk_in,
	input wire logic sync_in,
	input wire logic [4:0] lag_in,
	input wire logic [1:0] rx_in,
	output logic [1:0] sync_done_out,
	output logic [1:0] boundary_out
);
	logic [5:0] cnt_q [2] = '{6'h00, 6'h00};
	assign sync_done_out = {2{sync_in}};
	// Boundary follows every rx pulse; before sync the design is not counting
	for (genvar i = 0; i < 2; i++) begin : g_ln
		assign boundary_out[i] = cnt_q[i] == 6'h01;
		always @(posedge clk_in) begin
			cnt_q[i] <= rx_in[i] ? 6'(lag_in) + 6'(i + 1) : cnt_q[i] - {5'h00, |cnt_q[i]};
		end
	end
endmodule : srla_far

// ==== bench/srla_core_bench.sv ====
`timescale 1ns/10ps
module srla_core_bench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic sync = 1'b0;
	logic mf = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [7:0] wdata = 8'h00;
	logic [4:0] lag = 5'h04;
	logic [4:0] ph = 5'h00;
	logic [7:0] rdata;
	logic [1:0] en, rx, bnd, sd, brd;
	logic [3:0] ev;
	logic [7:0] gap_n;
	logic [7:0] rst_tab [10] = '{8'h0, 8'h1, 8'h0, 8'h0, 8'h0, 8'h0, 8'h6, 8'h6, 8'h0, 8'h0};
	int error_cnt = 0;
	int checks_done = 0;
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		ph <= ph + 5'h01;
		mf <= ph[4] && rst_n;
	end
	// Frame tick lands on the multiframe edge, four core clocks per frame
	srla_core dut (.core_clk_in(clk), .rst_n_in(rst_n), .frame_tick_in(ph[1:0] == 2'h1),
		.multiframe_clock_in(mf), .sync_done_in(sd), .boundary_in(bnd), .rx_data_valid_in(sd),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_rdata_out(rdata), .link_enable_out(en), .rx_multiframe_clock0_out(rx[0]),
		.rx_multiframe_clock1_out(rx[1]), .buffer_read_out(brd));
	srla_far far (.clk_in(clk), .sync_in(sync), .lag_in(lag), .rx_in(rx), .sync_done_out(sd),
		.boundary_out(bnd));
	assign ev = {brd, rx};
	task automatic wrap_up;
		if (error_cnt == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask : chk
	task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk("rdata", e, rdata);
	endtask : rd_chk
	// Cycles from a pulse on ev[a] to the next pulse on ev[b]
	task automatic gap(input int a, input int b, output logic [7:0] n);
		int w;
		logic hit_a;
		w = 0;
		n = 8'h00;
		do begin
			@(negedge clk);
			w++;
		end while (w < 100 && ev[a] !== 1'b1);
		hit_a = (ev[a] === 1'b1);
		do begin
			@(negedge clk);
			n++;
		end while (n < 8'h40 && ev[b] !== 1'b1);
		if (!hit_a || ev[b] !== 1'b1) begin
			error_cnt++;
			wrap_up;
		end
	endtask : gap
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 10; i++)
			rd_chk(12'h300 + 12'(i), rst_tab[i]);
		wr_reg(12'h301, 8'hff);
		rd_chk(12'h301, 8'h07);
		wr_reg(12'h301, 8'h00);
		rd_chk(12'h301, 8'h00);
		wr_reg(12'h302, 8'h1f);
		rd_chk(12'h302, 8'h00);
		for (int i = 3; i >= 0; i--) begin
			wr_reg(12'h300, 8'(i));
			rd_chk(12'h300, 8'(i));
			chk("link_en", 8'(i), {6'h00, en});
		end
		wr_reg(12'h305, 8'h02);
		wr_reg(12'h307, 8'h0a);
		wr_reg(12'h300, 8'h03);
		gap(0, 1, gap_n);
		chk("mf_gap_sc0", 8'h02, gap_n);
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			lag <= 5'(4 + 5 * k);
			sync <= 1'b1;
			gap(1, 3, gap_n);
			chk("rd_gap", 8'h0b, gap_n);
			rd_chk(12'h302, 8'(4 + 5 * k));
			rd_chk(12'h303, 8'(5 + 5 * k));
			@(posedge clk);
			sync <= 1'b0;
			repeat (2) @(posedge clk);
		end
		wr_reg(12'h301, 8'h01);
		gap(0, 1, gap_n);
		// Two frames of four core clocks each
		chk("mf_gap_sc1", 8'h08, gap_n);
		wrap_up;
	end
endmodule : srla_core_bench
